// *** core/option_loader_pkg.sv ***
// Shared constants, field layouts and types of the configuration byte loader.
package option_loader_pkg;

   // Flash locations of the configuration bytes.
   localparam logic [15:0] OPT_BASE_PRIMARY = 16'h0080;
   localparam logic [15:0] OPT_BASE_ALT = 16'h1080;
   localparam logic [15:0] POC_COPY_ADDR = 16'h0081;
   localparam logic [2:0] OPT_LAST_IDX = 3'h4;
   localparam logic [2:0] IDX_WDT = 3'h0;
   localparam logic [2:0] IDX_POC = 3'h1;
   localparam logic [2:0] IDX_DBG = 3'h4;

   // Field positions inside the bytes.
   localparam int WIN_HI = 6;
   localparam int WIN_LO = 5;
   localparam int RUN_EN_BIT = 4;
   localparam int OVF_HI = 3;
   localparam int OVF_LO = 1;
   localparam int LOCK_BIT = 0;
   localparam int POC_SEL_BIT = 0;
   localparam int DBG_HI = 1;
   localparam int DBG_LO = 0;
   localparam int STOP_REQ_BIT = 1;

   // Field codes and reset values.
   localparam logic [4:0] OVF_BASE_EXP = 5'h0a;
   localparam logic [1:0] WIN_25PCT = 2'h0;
   localparam logic [2:0] OVF_SHORTEST = 3'h0;
   localparam logic POC_MODE_SINGLE = 1'b0;
   localparam logic [1:0] DBG_OFF = 2'h0;
   localparam logic [1:0] DBG_BAD = 2'h1;
   localparam logic [1:0] DBG_ERASE = 2'h3;
   localparam logic [7:0] BYTE_RESET = 8'h00;

   // Register map: printed offsets are indices, byte address is four times the index.
   localparam logic [7:0] REG_IDX_WDT_CFG = 8'h80;
   localparam logic [7:0] REG_IDX_POC_CFG = 8'h81;
   localparam logic [7:0] REG_IDX_RSVD_A = 8'h82;
   localparam logic [7:0] REG_IDX_RSVD_B = 8'h83;
   localparam logic [7:0] REG_IDX_DBG_CFG = 8'h84;
   localparam logic [11:0] ADDR_OSC_MODE = 12'h000;
   localparam logic [11:0] ADDR_STATUS = 12'h004;

   typedef enum logic [1:0] {FS_IDLE = 2'b00, FS_FETCH = 2'b01, FS_COPY = 2'b11, FS_DONE = 2'b10} fetch_state_e;

   // Flash address of one configuration byte in the chosen bank.
   function automatic logic [15:0] option_addr(input logic alt, input logic [2:0] idx);
      option_addr = (alt ? OPT_BASE_ALT : OPT_BASE_PRIMARY) + {13'h0000, idx};
   endfunction : option_addr

   // Bus byte address of a register index.
   function automatic logic [11:0] reg_addr(input logic [7:0] idx);
      reg_addr = {2'b00, idx, 2'b00};
   endfunction : reg_addr

endpackage : option_loader_pkg

// *** core/fetch_if.sv ***
// Signals between the loader top and its flash fetch sequencer.
interface fetch_if;
   logic alt_bank;
   logic copy_en;
   logic done;
   logic copied;
   logic [4:0][7:0] bytes;
   logic flash_req;
   logic flash_we;
   logic [15:0] flash_addr;
   logic [7:0] flash_wdata;
   logic [7:0] flash_rdata;
   logic flash_ack;

   modport fetcher (input alt_bank, input copy_en, input flash_rdata, input flash_ack, output done,
      output copied, output bytes, output flash_req, output flash_we, output flash_addr, output flash_wdata);
   modport owner (output alt_bank, output copy_en, output flash_rdata, output flash_ack, input done,
      input copied, input bytes, input flash_req, input flash_we, input flash_addr, input flash_wdata);
endinterface : fetch_if

// *** core/option_fetch.sv ***
// Sequencer that reads the five configuration bytes from flash and performs the swap copy.
module option_fetch
   import option_loader_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   fetch_if.fetcher fb
);
   fetch_state_e state_q;
   logic [2:0] idx_q;
   logic [4:0][7:0] bytes_q;
   logic alt_q;
   logic copied_q;

   // Walk the bytes one request at a time, then optionally copy, then stop until the next reset.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_q <= FS_IDLE;
      end else begin
         unique case (state_q)
            FS_IDLE: state_q <= FS_FETCH;
            FS_FETCH: if (fb.flash_ack && idx_q == OPT_LAST_IDX) state_q <= fb.copy_en ? FS_COPY : FS_DONE;
            FS_COPY: if (fb.flash_ack) state_q <= FS_DONE;
            FS_DONE: state_q <= FS_DONE;
         endcase
      end
   end

   // The bank is chosen once, so a late swap change cannot mix bytes of two banks.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) alt_q <= 1'b0;
      else if (state_q == FS_IDLE) alt_q <= fb.alt_bank;
   end

   // Byte index and captured data.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         idx_q <= 3'h0;
         bytes_q <= '0;
      end else if (state_q == FS_FETCH && fb.flash_ack) begin
         idx_q <= idx_q + 3'h1;
         bytes_q[idx_q] <= fb.flash_rdata;
      end
   end

   // Completion of the copy into the primary bank.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) copied_q <= 1'b0;
      else if (state_q == FS_COPY && fb.flash_ack) copied_q <= 1'b1;
   end

   assign fb.flash_req = (state_q == FS_FETCH) || (state_q == FS_COPY);
   assign fb.flash_we = (state_q == FS_COPY);
   assign fb.flash_addr = (state_q == FS_COPY) ? POC_COPY_ADDR : option_addr(alt_q, idx_q);
   assign fb.flash_wdata = bytes_q[IDX_POC];
   assign fb.done = (state_q == FS_DONE);
   assign fb.copied = copied_q;
   assign fb.bytes = bytes_q;

   property p_bank_range;
      @(posedge clk) disable iff (rst)
      (state_q == FS_FETCH) |-> fb.flash_addr == option_addr(alt_q, idx_q) && idx_q <= OPT_LAST_IDX;
   endproperty
   a_bank_range: assert property (p_bank_range) else $error("fetch address outside option area");

   property p_copy_target;
      @(posedge clk) disable iff (rst)
      fb.flash_we |-> fb.flash_addr == POC_COPY_ADDR && fb.flash_wdata == bytes_q[IDX_POC] && alt_q;
   endproperty
   a_copy_target: assert property (p_copy_target) else $error("swap copy wrong address or data");

endmodule : option_fetch

// *** core/option_wdt_clock_ctrl.sv ***
// Slow oscillator run control and watchdog count clock gating.
module option_wdt_clock_ctrl
   import option_loader_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic loaded,
   input wire logic osc_lock,
   input wire logic stop_req,
   input wire logic run_enable,
   input wire logic halt_mode,
   input wire logic stop_mode,
   output logic slow_osc_run,
   output logic wdt_count_en
);
   logic osc_run_q;
   logic count_en_q;

   // Until the configuration is loaded the oscillator runs and the watchdog waits.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         osc_run_q <= 1'b1;
         count_en_q <= 1'b0;
      end else begin
         osc_run_q <= !loaded || osc_lock || !stop_req;
         // Self programming is not an input here on purpose: the count never pauses for it.
         count_en_q <= loaded && run_enable && (osc_lock || !stop_req)
            && !(!osc_lock && (halt_mode || stop_mode));
      end
   end

   assign slow_osc_run = osc_run_q;
   assign wdt_count_en = count_en_q;

endmodule : option_wdt_clock_ctrl

// *** core/option_byte_config_loader.sv ***
// Top of the reset-time configuration byte loader with its bus registers.
module option_byte_config_loader
   import option_loader_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic flash_req,
   output logic flash_we,
   output logic [15:0] flash_addr,
   output logic [7:0] flash_wdata,
   input wire logic [7:0] flash_rdata,
   input wire logic flash_ack,
   input wire logic boot_swap,
   input wire logic self_prog_active,
   input wire logic chip_erased,
   input wire logic halt_mode,
   input wire logic stop_mode,
   input wire logic vdd_above_2v7,
   input wire logic vdd_above_1v59,
   output logic config_loaded,
   output logic cpu_hold,
   output logic [1:0] wdt_window_sel,
   output logic wdt_run_enable,
   output logic illegal_access_det_en,
   output logic [2:0] wdt_overflow_sel,
   output logic [4:0] wdt_overflow_exp,
   output logic slow_osc_lock,
   output logic slow_osc_run,
   output logic wdt_count_en,
   output logic power_on_clear_threshold_sel,
   output logic power_on_clear,
   output logic debug_enable,
   output logic debug_erase_on_fail
);
   fetch_if fb ();

   logic loaded_q;
   logic [1:0] window_q;
   logic run_en_q;
   logic [2:0] ovf_sel_q;
   logic lock_q;
   logic poc_sel_q;
   logic [1:0] dbg_q;
   logic stop_req_q;
   logic reached_2v7_q;
   logic v27_meta_q;
   logic v27_q;
   logic v159_meta_q;
   logic v159_q;
   logic [31:0] prdata_q;
   logic pslverr_q;
   logic setup;
   logic [31:0] rd_value;
   logic rd_hit;

   // Overflow exponent is the base plus the select field.
   function automatic logic [4:0] ovf_exponent(input logic [2:0] sel);
      ovf_exponent = OVF_BASE_EXP + {2'b00, sel};
   endfunction : ovf_exponent

   // The prohibited debug code is read as debug off so a bad byte never opens the port.
   function automatic logic [1:0] debug_code(input logic [7:0] cfg);
      debug_code = (cfg[DBG_HI:DBG_LO] == DBG_BAD) ? DBG_OFF : cfg[DBG_HI:DBG_LO];
   endfunction : debug_code

   option_fetch u_fetch (
      .clk(clk),
      .rst(rst),
      .fb(fb.fetcher)
   );

   // Bank choice and the swap copy; the copy only lands on a freshly chip-erased array.
   assign fb.alt_bank = boot_swap;
   assign fb.copy_en = boot_swap && chip_erased;
   assign fb.flash_rdata = flash_rdata;
   assign fb.flash_ack = flash_ack;
   assign flash_req = fb.flash_req;
   assign flash_we = fb.flash_we;
   assign flash_addr = fb.flash_addr;
   assign flash_wdata = fb.flash_wdata;

   // Comparator levels are asynchronous, so each passes two flip-flops.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         v27_meta_q <= 1'b0;
         v27_q <= 1'b0;
         v159_meta_q <= 1'b0;
         v159_q <= 1'b0;
      end else begin
         v27_meta_q <= vdd_above_2v7;
         v27_q <= v27_meta_q;
         v159_meta_q <= vdd_above_1v59;
         v159_q <= v159_meta_q;
      end
   end

   // Holding flops, written once when the fetch ends; no bus path reaches them.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         loaded_q <= 1'b0;
         window_q <= WIN_25PCT;
         run_en_q <= 1'b0;
         ovf_sel_q <= OVF_SHORTEST;
         lock_q <= 1'b0;
         poc_sel_q <= POC_MODE_SINGLE;
         dbg_q <= DBG_OFF;
      end else if (fb.done && !loaded_q) begin
         loaded_q <= 1'b1;
         window_q <= fb.bytes[IDX_WDT][WIN_HI:WIN_LO];
         run_en_q <= fb.bytes[IDX_WDT][RUN_EN_BIT];
         ovf_sel_q <= fb.bytes[IDX_WDT][OVF_HI:OVF_LO];
         lock_q <= fb.bytes[IDX_WDT][LOCK_BIT];
         // A swap during self programming keeps the single-threshold default.
         poc_sel_q <= (boot_swap && self_prog_active) ? POC_MODE_SINGLE : fb.bytes[IDX_POC][POC_SEL_BIT];
         dbg_q <= debug_code(fb.bytes[IDX_DBG]);
      end
   end

   // Dual mode remembers that the supply once passed the upper point.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) reached_2v7_q <= 1'b0;
      else if (loaded_q && v27_q) reached_2v7_q <= 1'b1;
   end

   // Software stop request for the slow oscillator, bit 1 of the mode register.
   // The write lands when the access phase completes, never in the setup cycle.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) stop_req_q <= 1'b0;
      else if (psel && penable && pwrite && paddr == ADDR_OSC_MODE) stop_req_q <= pwdata[STOP_REQ_BIT];
   end

   option_wdt_clock_ctrl u_clock_ctrl (
      .clk(clk),
      .rst(rst),
      .loaded(loaded_q),
      .osc_lock(lock_q),
      .stop_req(stop_req_q),
      .run_enable(run_en_q),
      .halt_mode(halt_mode),
      .stop_mode(stop_mode),
      .slow_osc_run(slow_osc_run),
      .wdt_count_en(wdt_count_en)
   );

   // Decoded settings toward the watchdog, oscillator, threshold and debug logic.
   assign config_loaded = loaded_q;
   assign wdt_window_sel = window_q;
   assign wdt_run_enable = run_en_q;
   assign illegal_access_det_en = run_en_q;
   assign wdt_overflow_sel = ovf_sel_q;
   assign wdt_overflow_exp = ovf_exponent(ovf_sel_q);
   assign slow_osc_lock = lock_q;
   assign power_on_clear_threshold_sel = poc_sel_q;
   assign debug_enable = dbg_q[DBG_HI];
   assign debug_erase_on_fail = (dbg_q == DBG_ERASE);

   // In dual mode the clear stays on until the upper point is seen, then follows the lower one.
   assign power_on_clear = !v159_q || (poc_sel_q && !reached_2v7_q);
   // Normal operation waits for the load and for a released clear.
   assign cpu_hold = !loaded_q || power_on_clear;

   // Read multiplexer; reserved bytes read as stored so software can see a bad image.
   always_comb begin
      rd_value = 32'h0000_0000;
      rd_hit = 1'b1;
      unique case (paddr)
         ADDR_OSC_MODE: rd_value[STOP_REQ_BIT] = stop_req_q;
         ADDR_STATUS: rd_value[5:0] = {reached_2v7_q, fb.copied, fb.bytes[IDX_DBG][DBG_HI:DBG_LO] == DBG_BAD,
            fb.bytes[IDX_WDT][WIN_HI:WIN_LO] == WIN_25PCT && fb.bytes[IDX_WDT][OVF_HI:OVF_LO] == OVF_SHORTEST,
            boot_swap, loaded_q};
         reg_addr(REG_IDX_WDT_CFG): rd_value[7:0] = fb.bytes[0];
         reg_addr(REG_IDX_POC_CFG): rd_value[7:0] = fb.bytes[1];
         reg_addr(REG_IDX_RSVD_A): rd_value[7:0] = fb.bytes[2];
         reg_addr(REG_IDX_RSVD_B): rd_value[7:0] = fb.bytes[3];
         reg_addr(REG_IDX_DBG_CFG): rd_value[7:0] = fb.bytes[4];
         default: rd_hit = 1'b0;
      endcase
   end

   // The answer is prepared in the setup cycle so that data leave a flip-flop in the access cycle.
   assign setup = psel && !penable;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         prdata_q <= 32'h0000_0000;
         pslverr_q <= 1'b0;
      end else if (setup) begin
         prdata_q <= pwrite ? 32'h0000_0000 : rd_value;
         pslverr_q <= !rd_hit;
      end
   end

   assign prdata = prdata_q;
   assign pslverr = pslverr_q;
   assign pready = 1'b1;

   // Watchdog, oscillator, reset, load, copy, debug and register bus checks.
   property p_window_follows_byte;
      @(posedge clk) disable iff (rst)
      $rose(loaded_q) |-> wdt_window_sel == fb.bytes[IDX_WDT][WIN_HI:WIN_LO];
   endproperty
   a_window_follows_byte: assert property (p_window_follows_byte) else $error("window select mismatch");

   property p_count_needs_enable;
      @(posedge clk) disable iff (rst)
      wdt_count_en |-> wdt_run_enable && illegal_access_det_en && config_loaded;
   endproperty
   a_count_needs_enable: assert property (p_count_needs_enable) else $error("watchdog counts while disabled");

   property p_overflow_exponent;
      @(posedge clk) disable iff (rst)
      config_loaded |-> wdt_overflow_exp == OVF_BASE_EXP + {2'b00, wdt_overflow_sel};
   endproperty
   a_overflow_exponent: assert property (p_overflow_exponent) else $error("overflow exponent wrong");

   property p_lock_keeps_osc;
      @(posedge clk) disable iff (rst)
      config_loaded && slow_osc_lock |=> slow_osc_run;
   endproperty
   a_lock_keeps_osc: assert property (p_lock_keeps_osc) else $error("locked oscillator stopped");

   property p_stop_honoured;
      @(posedge clk) disable iff (rst)
      config_loaded && !slow_osc_lock && stop_req_q |=> !slow_osc_run && !wdt_count_en;
   endproperty
   a_stop_honoured: assert property (p_stop_honoured) else $error("stop request ignored");

   property p_halt_gates_count;
      @(posedge clk) disable iff (rst)
      !slow_osc_lock && (halt_mode || stop_mode) |=> !wdt_count_en;
   endproperty
   a_halt_gates_count: assert property (p_halt_gates_count) else $error("count clock during halt");

   property p_self_prog_counts;
      @(posedge clk) disable iff (rst)
      self_prog_active && config_loaded && wdt_run_enable && !halt_mode && !stop_mode && !stop_req_q
         |=> wdt_count_en;
   endproperty
   a_self_prog_counts: assert property (p_self_prog_counts) else $error("count paused by self programming");

   property p_dual_holds;
      @(posedge clk) disable iff (rst)
      power_on_clear_threshold_sel && !reached_2v7_q |-> power_on_clear && cpu_hold;
   endproperty
   a_dual_holds: assert property (p_dual_holds) else $error("dual mode released before upper point");

   property p_dual_lower_only;
      @(posedge clk) disable iff (rst)
      reached_2v7_q && v159_q && !v27_q |-> !power_on_clear;
   endproperty
   a_dual_lower_only: assert property (p_dual_lower_only) else $error("clear at upper point after start");

   property p_selfprog_default;
      @(posedge clk) disable iff (rst)
      $rose(loaded_q) && $past(boot_swap) && $past(self_prog_active) |-> power_on_clear_threshold_sel == POC_MODE_SINGLE;
   endproperty
   a_selfprog_default: assert property (p_selfprog_default) else $error("threshold mode changed by self program");

   property p_copy_needs_erase;
      @(posedge clk) disable iff (rst)
      flash_we |-> chip_erased || $past(chip_erased);
   endproperty
   a_copy_needs_erase: assert property (p_copy_needs_erase) else $error("copy without chip erase");

   property p_debug_decode;
      @(posedge clk) disable iff (rst)
      $rose(loaded_q) |-> debug_enable == (fb.bytes[IDX_DBG][DBG_HI:DBG_LO] inside {2'h2, 2'h3})
         && debug_erase_on_fail == (fb.bytes[IDX_DBG][DBG_HI:DBG_LO] == DBG_ERASE);
   endproperty
   a_debug_decode: assert property (p_debug_decode) else $error("debug control decode wrong");

   property p_fields_held;
      @(posedge clk) disable iff (rst)
      config_loaded |=> $stable({wdt_window_sel, wdt_run_enable, wdt_overflow_sel, slow_osc_lock,
         power_on_clear_threshold_sel, debug_enable, debug_erase_on_fail});
   endproperty
   a_fields_held: assert property (p_fields_held) else $error("held field changed after load");

   property p_load_before_run;
      @(posedge clk) disable iff (rst)
      !config_loaded |-> cpu_hold && !wdt_count_en;
   endproperty
   a_load_before_run: assert property (p_load_before_run) else $error("running before load");

   property p_apb_error;
      @(posedge clk) disable iff (rst)
      psel && !penable && !rd_hit |=> pslverr && prdata == 32'h0000_0000;
   endproperty
   a_apb_error: assert property (p_apb_error) else $error("unmapped access not refused");

   // Load sequencing, register bus, swap copy and power-on clear checks.
   property p_no_fetch_after_load;
      @(posedge clk) disable iff (rst)
      config_loaded |-> !flash_req && !flash_we;
   endproperty
   a_no_fetch_after_load: assert property (p_no_fetch_after_load) else $error("flash access after load");

   property p_stop_write;
      @(posedge clk) disable iff (rst)
      psel && penable && pwrite && paddr == ADDR_OSC_MODE && pwdata[STOP_REQ_BIT] |=> stop_req_q;
   endproperty
   a_stop_write: assert property (p_stop_write) else $error("stop request write lost");

   property p_copy_needs_swap;
      @(posedge clk) disable iff (rst)
      fb.copied |-> boot_swap && chip_erased;
   endproperty
   a_copy_needs_swap: assert property (p_copy_needs_swap) else $error("copy without swap and erase");

   property p_single_lower_only;
      @(posedge clk) disable iff (rst)
      config_loaded && !power_on_clear_threshold_sel |-> power_on_clear == !v159_q;
   endproperty
   a_single_lower_only: assert property (p_single_lower_only) else $error("single mode clear wrong");

   c_swap_copy: cover property (@(posedge clk) disable iff (rst) fb.copied && config_loaded);
   c_dual_mode: cover property (@(posedge clk) disable iff (rst) power_on_clear_threshold_sel && reached_2v7_q);
   c_debug_erase: cover property (@(posedge clk) disable iff (rst) config_loaded && debug_erase_on_fail);
   c_halt_gate: cover property (@(posedge clk) disable iff (rst) wdt_run_enable && halt_mode && !slow_osc_lock);
   c_stop_request: cover property (@(posedge clk) disable iff (rst) config_loaded && stop_req_q && !slow_osc_lock);

endmodule : option_byte_config_loader

// *** sim/flash_model.sv ***
// Flash array model answering loader requests after a short random delay.
module flash_model (
   input wire logic clk,
   input wire logic flash_req,
   input wire logic flash_we,
   input wire logic [15:0] flash_addr,
   input wire logic [7:0] flash_wdata,
   output logic [7:0] flash_rdata,
   output logic flash_ack
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] mem [logic [15:0]];
   int wait_q = 0;
   // Answer after zero to three cycles; outside an answer the data inverts so stale data never matches.
   always @(posedge clk) begin
      flash_ack <= 1'b0;
      flash_rdata <= ~flash_rdata;
      if (flash_req && flash_ack !== 1'b1) begin
         if (wait_q == 0) begin
            flash_ack <= 1'b1;
            if (flash_we) mem[flash_addr] = flash_wdata;
            else flash_rdata <= mem[flash_addr];
            wait_q = $urandom_range(3, 0);
         end else wait_q--;
      end
   end
endmodule : flash_model

// *** sim/test_option_byte_config_loader.sv ***
// Self-checking bench of the configuration byte loader against a flash model.
module test_option_byte_config_loader
   import option_loader_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk, rst, psel, penable, pwrite, pready, pslverr, flash_req, flash_we, flash_ack, boot_swap;
   logic self_prog_active, chip_erased, halt_mode, stop_mode, vdd_above_2v7, vdd_above_1v59, config_loaded;
   logic cpu_hold, wdt_run_enable, illegal_access_det_en, slow_osc_lock, slow_osc_run, wdt_count_en;
   logic power_on_clear_threshold_sel, power_on_clear, debug_enable, debug_erase_on_fail;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [15:0] flash_addr;
   logic [7:0] flash_wdata, flash_rdata;
   logic [1:0] wdt_window_sel;
   logic [2:0] wdt_overflow_sel;
   logic [4:0] wdt_overflow_exp;
   int errors = 0;
   int comparisons = 0;
   option_byte_config_loader dut (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
      .pslverr, .flash_req, .flash_we, .flash_addr, .flash_wdata, .flash_rdata, .flash_ack, .boot_swap,
      .self_prog_active, .chip_erased, .halt_mode, .stop_mode, .vdd_above_2v7, .vdd_above_1v59, .config_loaded,
      .cpu_hold, .wdt_window_sel, .wdt_run_enable, .illegal_access_det_en, .wdt_overflow_sel, .wdt_overflow_exp,
      .slow_osc_lock, .slow_osc_run, .wdt_count_en, .power_on_clear_threshold_sel, .power_on_clear,
      .debug_enable, .debug_erase_on_fail);
   flash_model flash (.clk, .flash_req, .flash_we, .flash_addr, .flash_wdata, .flash_rdata, .flash_ack);
   // Free-running system clock.
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   // Compares one value and counts it.
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         errors++;
         $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : check
   // Prints the counts and the verdict, then stops.
   task automatic results();
      $display("comparisons %0d errors %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : results
   // One APB transfer; the request holds until pready is seen, and an idle edge follows so calls chain safely.
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r,
      output logic e);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask : apb
   // Decoded outputs expected from the watchdog, threshold and debug bytes.
   function automatic logic [31:0] exp_fields(input logic [7:0] w, input logic [7:0] c, input logic [7:0] d,
      input logic sp);
      exp_fields = {16'h0, w[6:5], w[4], w[4], w[3:1], 5'(10 + w[3:1]), w[0], c[0] & !sp, d[1], d[1:0] == 2'h3};
   endfunction : exp_fields
   // Hang guard, far beyond the several hundred cycles the tests need.
   initial begin
      repeat (20000) @(posedge clk);
      errors++;
      results();
   end
   // Eight loads covering every swap, erase and self-programming combination; the loaded debug code is only ever 0 or 2.
   initial begin
      logic [7:0] pb [5];
      logic [7:0] ab [5];
      logic [7:0] b [5];
      logic [31:0] r;
      logic e, sw, sp, ce;
      int i, k;
      {psel, penable, pwrite, paddr, pwdata, boot_swap, self_prog_active, chip_erased} = '0;
      rst = 1'b1;
      {halt_mode, stop_mode, vdd_above_2v7, vdd_above_1v59} = '0;
      void'($urandom(32'hf567e954));
      for (i = 0; i < 8; i++) begin
         pb = '{default: 8'h00};
         ab = '{default: 8'h00};
         pb[0] = {1'b0, 7'($urandom)};
         ab[0] = {1'b0, 7'($urandom)};
         if ({pb[0][6:5], pb[0][3:1]} == 5'h00) pb[0][1] = 1'b1;
         if ({ab[0][6:5], ab[0][3:1]} == 5'h00) ab[0][1] = 1'b1;
         pb[1] = {7'h00, 1'($urandom)};
         ab[1] = {7'h00, ~pb[1][0]};
         pb[4] = 8'(i % 4);
         ab[4] = 8'((i + 1) % 4);
         {ce, sp, sw} = 3'(i);
         for (k = 0; k < 5; k++) begin
            flash.mem[16'h0080 + 16'(k)] = pb[k];
            flash.mem[16'h1080 + 16'(k)] = ab[k];
            b[k] = sw ? ab[k] : pb[k];
         end
         @(posedge clk);
         {boot_swap, self_prog_active, chip_erased, rst, vdd_above_1v59} <= {sw, sp, ce, 2'b11};
         repeat (3) @(posedge clk);
         rst <= 1'b0;
         while (config_loaded !== 1'b1) @(posedge clk);
         @(posedge clk);
         check({16'h0, wdt_window_sel, wdt_run_enable, illegal_access_det_en, wdt_overflow_sel, wdt_overflow_exp,
            slow_osc_lock, power_on_clear_threshold_sel, debug_enable, debug_erase_on_fail},
            exp_fields(b[0], b[1], b[4], sw & sp));
         check(32'(flash.mem[16'h0081]), 32'((sw && ce) ? ab[1] : pb[1]));
         check(32'({power_on_clear, cpu_hold}), {30'h0, {2{b[1][0] & !(sw & sp)}}});
         // Supply walk: pass 2.7 V, fall below it, then fall below 1.59 V.
         vdd_above_2v7 <= 1'b1;
         repeat (4) @(posedge clk);
         vdd_above_2v7 <= 1'b0;
         repeat (4) @(posedge clk);
         check(32'({power_on_clear, cpu_hold, wdt_count_en}), 32'({2'b00, b[0][4]}));
         vdd_above_1v59 <= 1'b0;
         repeat (4) @(posedge clk);
         check(32'(power_on_clear), 32'h1);
         {vdd_above_1v59, halt_mode, stop_mode} <= {1'b1, !sw, sw};
         repeat (4) @(posedge clk);
         check(32'(wdt_count_en), 32'(b[0][4] & b[0][0]));
         {halt_mode, stop_mode} <= 2'b00;
         apb(1'b1, 12'h000, 32'h2, r, e);
         repeat (2) @(posedge clk);
         check(32'({slow_osc_run, wdt_count_en}), 32'({b[0][0], b[0][4] & b[0][0]}));
         apb(1'b0, 12'h000, 32'h0, r, e);
         check(r, 32'h2);
         apb(1'b0, 12'h004, 32'h0, r, e);
         check(r, {26'h0, 1'b1, sw & ce, b[4][1:0] == 2'h1, 1'b0, sw, 1'b1});
         for (k = 0; k < 5; k++) begin
            apb(1'b1, 12'h200 + 12'(4 * k), 32'hff, r, e);
            apb(1'b0, 12'h200 + 12'(4 * k), 32'h0, r, e);
            check(r, {24'h0, b[k]});
            check(32'(e), 32'h0);
         end
         apb(1'b0, 12'h300, 32'h0, r, e);
         check(32'(e), 32'h1);
         $display("test %0d done", i);
      end
      results();
   end
endmodule : test_option_byte_config_loader
